// ===== include/sdods_pkg.sv
// constants and types for the sda output delay select block
// assumes an apb master on pclk and a free main oscillator clock on a pin
package sdods_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] ADDR_MODE = 12'h000; // channel_special_mode_reg
  localparam logic [11:0] ADDR_DELAY = 12'h004; // sda_delay_setup_register
  localparam int unsigned MODE_SEL_BIT = 7; // sda_delay_mode_select
  localparam int unsigned CODE_MSB = 7; // sda_delay_code_bit2
  localparam int unsigned CODE_LSB = 5; // sda_delay_code_bit0
  localparam int unsigned CODE_W = 3;
  localparam logic [2:0] CODE_ANALOG = 3'h0;
  localparam logic MODE_SEL_RESET = 1'b0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W = 4;
  // one extra oscillator edge covers the unknown phase of the first one
  localparam logic [3:0] CNT_EXTRA = 4'h1;
  localparam logic [3:0] CNT_LAST = 4'h1;
  localparam logic SDA_IDLE = 1'b1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic mode_sel;
    logic [2:0] code;
  } sdods_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_COUNT = 2'b10
  } sdods_state_t;

endpackage

// ===== logic/sdods_delay_counter.sv
// digital delay counter for the sda output
// assumes xin_rise is a one-cycle pulse already synchronised to pclk
`timescale 1ns/1ps
`default_nettype none
module sdods_delay_counter
  import sdods_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic clear,
  input wire logic xin_rise,
  input wire logic [sdods_pkg::CODE_W-1:0] code,
  input wire logic sda_req,
  output logic sda_dly,
  output logic busy
);

  sdods_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic tgt_r, tgt_nxt;
  logic out_r, out_nxt;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // restart on any new change so the pin never shows a short pulse
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    tgt_nxt = tgt_r;
    out_nxt = out_r;
    case (state_r)
      ST_IDLE: begin
        if (clear) begin
          out_nxt = sda_req;
        end else if (sda_req != out_r) begin
          tgt_nxt = sda_req;
          cnt_nxt = {1'b0, code} + CNT_EXTRA;
          state_nxt = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (clear) begin
          out_nxt = sda_req;
          state_nxt = ST_IDLE;
        end else if (sda_req != tgt_r) begin
          tgt_nxt = sda_req;
          cnt_nxt = {1'b0, code} + CNT_EXTRA;
        end else if (xin_rise) begin
          if (cnt_r == CNT_LAST) begin
            out_nxt = tgt_r;
            state_nxt = ST_IDLE;
          end else begin
            cnt_nxt = cnt_r - CNT_LAST;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // state registers, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      tgt_r <= SDA_IDLE;
      out_r <= SDA_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      tgt_r <= tgt_nxt;
      out_r <= out_nxt;
    end
  end

  assign sda_dly = out_r;
  assign busy = (state_r == ST_COUNT);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_LOAD_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state_r == ST_IDLE && !clear && sda_req != out_r)
    |=> (state_r == ST_COUNT && cnt_r == {1'b0, $past(code)} + CNT_EXTRA))
    else $error("counter not loaded with code plus one");

  AST_HOLD_WHILE_COUNTING: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_COUNT && !clear && !(xin_rise && cnt_r == CNT_LAST))
    |=> (out_r == $past(out_r)))
    else $error("delayed sda changed before count ended");

  AST_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state_r == ST_COUNT && !clear && sda_req == tgt_r && xin_rise
      && cnt_r == CNT_LAST)
    |=> (out_r == $past(tgt_r) && state_r == ST_IDLE))
    else $error("delayed sda not released at last edge");

  COV_RELEASE: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_COUNT ##1 state_r == ST_IDLE);

endmodule
`default_nettype wire

// ===== logic/sdods_top.sv
// sda output delay select: apb registers, oscillator sampling, output mux
// assumes sda_req comes from serial logic on pclk and xin is an async pin
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - code 000 routes sda through the analog path, no digital delay.
// - code n from 1 to 7 delays sda by n to n+1 oscillator periods.
// - analog and digital delay never combine; only one path is active.
// - mode select bit 7 makes the delay setup register writable.
// - with mode select 0, delay writes ignored and reads return all zeros.
// - after reset and while mode select is 0, code forced to 000.
// - first read of the delay setup register after setting mode select returns all zeros.
// - with mode select 1, reserved low bits read as zero.
module sdods_top
  import sdods_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sdods_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic xin,
  input wire logic sda_req,
  output logic sda_out,
  output logic sda_analog_sel
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic sdods_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    sdods_hit = (a == off);
  endfunction

  logic hit_mode, hit_delay, setup_rd, access, wr_mode, wr_delay;

  // decode shared by write, read capture and error answer
  assign hit_mode = sdods_hit(paddr, ADDR_MODE);
  assign hit_delay = sdods_hit(paddr, ADDR_DELAY);
  assign setup_rd = ce & psel & ~penable & ~pwrite;
  assign access = ce & psel & penable;
  assign wr_mode = access & pwrite & hit_mode;
  assign wr_delay = access & pwrite & hit_delay;
  assign pready = access;
  assign pslverr = access & ~(hit_mode | hit_delay);

  // ----------------------------------------------------------------
  // oscillator sampling
  // ----------------------------------------------------------------
  logic xin_s1_r, xin_s2_r, xin_s3_r;
  logic xin_lvl_r, xin_lvl_nxt;
  logic xin_rise;

  // filtered level moves only when stages two and three agree
  assign xin_lvl_nxt = (xin_s2_r == xin_s3_r) ? xin_s3_r : xin_lvl_r;

  // three stages; the edge counts once stages two and three agree on it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xin_s1_r <= 1'b0;
      xin_s2_r <= 1'b0;
      xin_s3_r <= 1'b0;
      xin_lvl_r <= 1'b0;
    end else if (ce) begin
      xin_s1_r <= xin;
      xin_s2_r <= xin_s1_r;
      xin_s3_r <= xin_s2_r;
      xin_lvl_r <= xin_lvl_nxt;
    end
  end

  // one pulse per oscillator rise, taken from xin_lvl_nxt so it costs no extra pclk of latency
  assign xin_rise = xin_lvl_nxt & ~xin_lvl_r;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  sdods_cfg_t cfg_r, cfg_nxt;
  logic [31:0] prdata_r, prdata_nxt;

  // writes land only in the access cycle; code clears with mode select
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_mode) begin
      cfg_nxt.mode_sel = pwdata[MODE_SEL_BIT];
    end
    if (wr_delay && cfg_r.mode_sel) begin
      // low bits are dropped, software is expected to write them as zero
      cfg_nxt.code = pwdata[CODE_MSB:CODE_LSB];
    end
    if (!cfg_nxt.mode_sel) begin
      cfg_nxt.code = CODE_ANALOG;
    end
  end

  // read data captured in the setup cycle so prdata comes from a flop
  always_comb begin
    prdata_nxt = prdata_r;
    if (setup_rd) begin
      prdata_nxt = RDATA_ZERO;
      if (hit_mode) begin
        prdata_nxt[MODE_SEL_BIT] = cfg_r.mode_sel;
      end else if (hit_delay && cfg_r.mode_sel) begin
        // reserved low bits stay zero
        prdata_nxt[CODE_MSB:CODE_LSB] = cfg_r.code;
      end
    end
  end

  // registers of the bus side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r.mode_sel <= MODE_SEL_RESET;
      cfg_r.code <= CODE_ANALOG;
      prdata_r <= RDATA_ZERO;
    end else if (ce) begin
      cfg_r <= cfg_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

  // ----------------------------------------------------------------
  // output path
  // ----------------------------------------------------------------
  logic analog;
  logic sda_dly;
  logic dly_busy;
  logic sda_out_r, sda_out_nxt;

  assign analog = (cfg_r.code == CODE_ANALOG);

  // counter is held clear in analog mode so both delays never stack
  sdods_delay_counter u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .clear(analog),
    .xin_rise(xin_rise),
    .code(cfg_r.code),
    .sda_req(sda_req),
    .sda_dly(sda_dly),
    .busy(dly_busy)
  );

  // one pclk of latency in analog mode; the pad adds the analog delay
  always_comb begin
    sda_out_nxt = analog ? sda_req : sda_dly;
  end

  // output flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_out_r <= SDA_IDLE;
    end else if (ce) begin
      sda_out_r <= sda_out_nxt;
    end
  end

  assign sda_out = sda_out_r;
  assign sda_analog_sel = analog;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic first_rd_r;

  // helper: armed when mode select rises, cleared by a delay access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_rd_r <= 1'b0;
    end else if (ce) begin
      if (!cfg_r.mode_sel && cfg_nxt.mode_sel) begin
        first_rd_r <= 1'b1;
      end else if (access && hit_delay) begin
        first_rd_r <= 1'b0;
      end
    end
  end

  AST_ANALOG_PASS: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && analog) |=> (sda_out == $past(sda_req)))
    else $error("analog mode did not pass sda straight through");

  AST_ANALOG_NO_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && analog) |=> !dly_busy)
    else $error("digital counter ran in analog mode");

  AST_DIGITAL_PATH: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !analog) |=> (sda_out == $past(sda_dly)))
    else $error("digital mode output not from counter");

  AST_WRITE_TAKES: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_delay && cfg_r.mode_sel && !wr_mode)
    |=> (cfg_r.code == $past(pwdata[CODE_MSB:CODE_LSB])))
    else $error("delay write with mode select set not stored");

  AST_WRITE_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_delay && !cfg_r.mode_sel) |=> (cfg_r.code == CODE_ANALOG))
    else $error("delay write accepted with mode select clear");

  AST_FORCE_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_r.mode_sel |-> (cfg_r.code == CODE_ANALOG && sda_analog_sel))
    else $error("code not forced to analog with mode select clear");

  AST_FIRST_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (first_rd_r && pready && !pwrite && hit_delay) |-> (prdata == RDATA_ZERO))
    else $error("first read after mode select not zero");

  AST_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && hit_delay) |-> (prdata[CODE_LSB-1:0] == 5'h00))
    else $error("reserved delay bits read nonzero");

  AST_ERR_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !hit_mode && !hit_delay) |-> (pslverr && prdata == RDATA_ZERO))
    else $error("unmapped access not answered with error");

  COV_DIGITAL: cover property (@(posedge pclk) disable iff (!presetn)
    !analog && dly_busy ##[1:200] !dly_busy);

  COV_WRITE_CODE: cover property (@(posedge pclk) disable iff (!presetn)
    wr_delay && cfg_r.mode_sel);

  COV_FIRST_READ: cover property (@(posedge pclk) disable iff (!presetn)
    first_rd_r && pready && !pwrite && hit_delay);

endmodule
`default_nettype wire

// ===== tb/sdods_osc_model.sv
// main oscillator model driving the xin pin of the delay block
// assumes nothing of the design; the oscillator runs free from time zero
`timescale 1ns/1ps
`default_nettype none
module sdods_osc_model #(
  parameter realtime HALF_NS = 62.5,
  parameter realtime PHASE_NS = 37.0
) (
  output var logic xin
);
  // ----------------------------------------------------------------
  // free running clock, phase unrelated to pclk
  // ----------------------------------------------------------------
  // odd start offset; one oscillator edge in four still lines up with a pclk edge, first at 162 ns
  initial begin
    xin = 1'b0;
    #(PHASE_NS);
    forever #(HALF_NS) xin = ~xin;
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the sda output delay select block
// assumes sdods_pkg is compiled first and xin comes from the oscillator model
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sdods_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, sda_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, xin, sda_out, sda_analog_sel, err, lvl0;
  int err_total, compares, n, bad;

  sdods_osc_model osc (.xin(xin));
  sdods_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .xin(xin), .sda_req(sda_req), .sda_out(sda_out),
    .sda_analog_sel(sda_analog_sel));

  // ----------------------------------------------------------------
  // clock, verdict and comparison
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("errors %0d, comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // apb master: setup, then access until pready at a rising edge
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int w;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    rd = prdata;
    err = pslverr;
    if (w >= 50) err_total++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // flips sda_req and counts pclk cycles until sda_out follows
  task automatic measure(output int cyc);
    logic lvl;
    lvl = ~sda_req;
    @(posedge pclk);
    sda_req <= lvl;
    cyc = 0;
    do begin
      @(posedge pclk);
      #1;
      cyc++;
    end while (sda_out !== lvl && cyc < 600);
  endtask

  // ----------------------------------------------------------------
  // watchdog: the tests need well under 40 us
  // ----------------------------------------------------------------
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    err_total = 0;
    compares = 0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    sda_req = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // reset state: analog path, idle sda, registers clear
    check(sda_out, 32'(SDA_IDLE));
    check(sda_analog_sel, 32'h1);
    apb(1'b0, ADDR_MODE, 32'h0);
    check(rd, 32'h0000_0000);
    // delay writes refused while mode select is clear
    apb(1'b1, ADDR_DELAY, 32'h0000_00E0);
    apb(1'b0, ADDR_DELAY, 32'h0);
    check(rd, RDATA_ZERO);
    check(sda_analog_sel, 32'h1);
    measure(n);
    check(n, 32'h1);
    // set mode select, first read of delay register is zero
    apb(1'b1, ADDR_MODE, 32'h0000_0080);
    apb(1'b0, ADDR_MODE, 32'h0);
    check(rd, 32'h0000_0080);
    apb(1'b0, ADDR_DELAY, 32'h0);
    check(rd, 32'h0000_0000);
    // every digital code: readback, path select, delay window
    for (int c = 1; c < 8; c++) begin
      apb(1'b1, ADDR_DELAY, 32'(c) << 5);
      apb(1'b0, ADDR_DELAY, 32'h0);
      check(rd, 32'(c) << 5);
      check(sda_analog_sel, 32'h0);
      measure(n);
      check(32'(n * 4 >= c * 125 && n * 4 <= (c + 1) * 125 + 40), 32'h1);
    end
    // a change withdrawn mid-count never reaches the pin
    apb(1'b1, ADDR_DELAY, 32'h0000_0060);
    lvl0 = sda_req;
    bad = 0;
    @(posedge pclk);
    sda_req <= ~lvl0;
    repeat (10) @(posedge pclk);
    sda_req <= lvl0;
    // the pin must never show the withdrawn level
    repeat (200) begin
      @(posedge pclk);
      #1;
      if (sda_out !== lvl0) bad++;
    end
    check(bad, 32'h0);
    check(sda_out, 32'(sda_req));
    // clearing mode select forces the analog code
    apb(1'b1, ADDR_MODE, 32'h0000_0000);
    #1;
    check(sda_analog_sel, 32'h1);
    apb(1'b0, ADDR_DELAY, 32'h0);
    check(rd, RDATA_ZERO);
    apb(1'b1, ADDR_MODE, 32'h0000_0080);
    apb(1'b0, ADDR_DELAY, 32'h0);
    check(rd, 32'h0000_0000);
    measure(n);
    check(n, 32'h1);
    // ce low freezes the output; it catches up once ce returns
    lvl0 = sda_req;
    @(posedge pclk);
    ce <= 1'b0;
    sda_req <= ~lvl0;
    repeat (20) @(posedge pclk);
    #1;
    check(sda_out, 32'(lvl0));
    @(posedge pclk);
    ce <= 1'b1;
    @(posedge pclk);
    #1;
    check(sda_out, 32'(sda_req));
    // unmapped address answers with an error and zero data
    apb(1'b0, 12'h010, 32'h0);
    check(err, 32'h1);
    check(rd, 32'h0000_0000);
    print_verdict();
  end
endmodule
`default_nettype wire
